// [rtl/pha_pkg.sv]
// shared types and constants for the processor-hot alert block
package pha_pkg;
    // clock period and register command codes
    localparam int CLK_NS = 20;
    localparam logic [7:0] ADDR_STAT = 8'h3A;
    localparam logic [7:0] ADDR_OPT0 = 8'h3C;
    localparam logic [7:0] ADDR_OPT1 = 8'h3D;
    localparam logic [15:0] OPT0_RESET = 16'h4A54;
    localparam logic [15:0] OPT1_RESET = 16'h8100;
    localparam logic [15:0] OPT0_WMASK = 16'hFEFE;
    localparam logic [15:0] OPT1_WMASK = 16'hFF7F;

    // source bit positions in profile mask and status
    localparam int SRC_COMP = 6;
    localparam int SRC_CRIT = 5;
    localparam int SRC_NOM = 4;
    localparam int SRC_DCHG = 3;
    localparam int SRC_SYSTEM_VOLTAGE_SOURCE = 2;
    localparam int SRC_BAT = 1;
    localparam int SRC_ADP = 0;
    localparam int SRC_N = 7;
    localparam logic [6:0] SRC_ALL = 7'h7F;
    localparam logic [6:0] KEEP_NO_ADP = 7'h4C;

    // threshold decode constants
    localparam logic [8:0] CRIT_PCT_FLOOR = 9'h06E;
    localparam logic [8:0] CRIT_PCT_BASE = 9'h069;
    localparam logic [8:0] CRIT_PCT_STEP = 9'h005;
    localparam logic [8:0] CRIT_PCT_300 = 9'h12C;
    localparam logic [8:0] CRIT_PCT_350 = 9'h15E;
    localparam logic [8:0] CRIT_PCT_450 = 9'h1C2;
    localparam logic [4:0] CRIT_CODE_300 = 5'h1B;
    localparam logic [4:0] CRIT_CODE_350 = 5'h1E;
    localparam logic [4:0] CRIT_CODE_450 = 5'h1F;
    localparam logic [8:0] NOM_PCT = 9'h06E;
    localparam logic [12:0] SYSTEM_VOLTAGE_SOURCE_MV_BASE = 13'h1676;
    localparam logic [12:0] SYSTEM_VOLTAGE_SOURCE_MV_STEP = 13'h00FA;
    localparam logic [14:0] DCHG_MA_STEP = 15'h0200;

    // times in ns and their cycle counts
    localparam int T_10US_NS = 10000;
    localparam int T_20US_NS = 20000;
    localparam int T_100US_NS = 100000;
    localparam int T_400US_NS = 400000;
    localparam int T_800US_NS = 800000;
    localparam int T_1MS_NS = 1000000;
    localparam int T_1M6_NS = 1600000;
    localparam int T_5MS_NS = 5000000;
    localparam int T_6MS_NS = 6000000;
    localparam int T_10MS_NS = 10000000;
    localparam int T_12MS_NS = 12000000;
    localparam int T_60MS_NS = 60000000;
    localparam int CYC_10US = (T_10US_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_20US = (T_20US_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_100US = (T_100US_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_400US = (T_400US_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_800US = (T_800US_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_1MS = T_1MS_NS / CLK_NS;
    localparam int CYC_1M6 = (T_1M6_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_5MS = (T_5MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_6MS = (T_6MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_10MS = (T_10MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_12MS = (T_12MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_60MS = T_60MS_NS / CLK_NS;
    localparam int CYC_ONE = 1;

    typedef logic [21:0] pha_cnt_t;

    typedef enum logic [0:0] {
        PHA_IDLE = 1'b0,
        PHA_LOW = 1'b1
    } pha_state_t;

    typedef struct packed {
        logic [4:0] crit_thr;
        logic [1:0] crit_deg;
        logic rsv8;
        logic [1:0] system_voltage_source_thr;
        logic ext_en;
        logic [1:0] width;
        logic pulse_clear;
        logic nom_deg;
        logic rsv0;
    } pha_opt0_t;

    typedef struct packed {
        logic [5:0] dchg_thr;
        logic [1:0] dchg_deg;
        logic rsv7;
        logic [6:0] profile;
    } pha_opt1_t;

    // sensed inputs, ordered as the source bit positions
    typedef struct packed {
        logic comp_trip;
        logic crit_over;
        logic nom_over;
        logic dchg_over;
        logic system_voltage_source_under;
        logic battery_presence;
        logic adapter_presence;
    } pha_sense_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } pha_host_req_t;

    typedef struct packed {
        logic [8:0] crit_pct;
        logic [12:0] system_voltage_source_mv;
        logic [14:0] dchg_ma;
    } pha_limits_t;

    typedef struct packed {
        pha_opt0_t opt0;
        pha_opt1_t opt1;
        logic [6:0] status;
        logic stat_armed;
        pha_state_t st;
        logic alert_b;
        logic [15:0] rdata;
        logic [6:0] sync1;
        logic [6:0] sync2;
        logic [1:0] pres_q;
        pha_limits_t lim;
    } pha_top_state_t;

    typedef struct packed {
        pha_cnt_t cnt;
        logic out;
    } pha_dg_state_t;

    typedef struct packed {
        pha_cnt_t cnt;
        logic run;
    } pha_tm_state_t;
endpackage : pha_pkg

// [rtl/pha_deglitch.sv]
// level deglitch filter: output rises after input held high for a period
`timescale 1ns/1ps
module pha_deglitch
    import pha_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic level_in,
    input wire pha_cnt_t period,
    output logic level_out
);
    pha_dg_state_t s;
    pha_dg_state_t next_s;

    // count high cycles, drop at once on low
    always_comb begin
        next_s = s;
        if (!level_in) begin
            next_s.cnt = '0;
            next_s.out = 1'b0;
        end else if (s.cnt >= period - pha_cnt_t'(1)) begin
            next_s.out = 1'b1;
        end else begin
            next_s.cnt = s.cnt + pha_cnt_t'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign level_out = s.out;
endmodule : pha_deglitch

// [rtl/pha_pulse_timer.sv]
// minimum pulse width timer
`timescale 1ns/1ps
module pha_pulse_timer
    import pha_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic start,
    input wire pha_cnt_t period,
    output logic done
);
    pha_tm_state_t s;
    pha_tm_state_t next_s;

    // restartable count of period cycles
    always_comb begin
        next_s = s;
        if (start) begin
            next_s.cnt = '0;
            next_s.run = 1'b1;
        end else if (s.run) begin
            if (s.cnt >= period - pha_cnt_t'(1)) begin
                next_s.run = 1'b0;
            end else begin
                next_s.cnt = s.cnt + pha_cnt_t'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign done = !s.run;
endmodule : pha_pulse_timer

// [rtl/pha_alert.sv]
// processor-hot alert configuration, source filtering and pulse generation
//
// Functional notes
// - critical threshold: 5-bit percent of input limit, 5% steps, reset 01001 = 150%
// - critical codes 0 and 1 are 110%, 2 is 115%; top codes 300/350/450%
// - critical event when input sense current exceeds critical threshold
// - critical deglitch 10us, 100us (reset), 400us, 800us
// - system voltage event when battery-side voltage below threshold for 20us
// - extension set holds alert low until host writes clear bit zero
// - minimum width 100us, 1ms, 10ms (reset), 5ms without extension
// - writing clear zero ends extended pulse; one is idle and reset value
// - nominal event when input current exceeds fixed 110% of limit
// - nominal deglitch 1ms (reset) or 60ms
// - discharge threshold 6-bit, 512mA steps, reset 100000; exceed fires event
// - discharge deglitch 1.6ms, 100us (reset), 6ms, 12ms
// - with adapter present, 7-bit profile mask selects alert sources
// - adapter removal disables critical, nominal, battery and adapter sources
// - all-zero profile keeps alert disabled
// - profile bit 6 enables independent comparator, off at reset
// - status flags per triggering source, cleared on read after release or new pulse
// - status bits: 6 comp, 5 crit, 4 nom, 3 dchg, 2 system_voltage_source, 1 bat, 0 adapter
`timescale 1ns/1ps
module pha_alert
    import pha_pkg::*;
#(
    parameter int P_100US = CYC_100US,
    parameter int P_400US = CYC_400US,
    parameter int P_800US = CYC_800US,
    parameter int P_1MS = CYC_1MS,
    parameter int P_1M6 = CYC_1M6,
    parameter int P_5MS = CYC_5MS,
    parameter int P_6MS = CYC_6MS,
    parameter int P_10MS = CYC_10MS,
    parameter int P_12MS = CYC_12MS,
    parameter int P_60MS = CYC_60MS
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire pha_host_req_t host_req,
    output logic [15:0] host_rdata,
    input wire pha_sense_t sense_in,
    output logic processor_hot_alert_b,
    output pha_limits_t limits,
    output logic [8:0] nom_limit_pct
);
    pha_top_state_t s;
    pha_top_state_t next_s;
    logic [6:0] filt;
    logic [6:0] events;
    logic [6:0] eff_mask;
    logic [6:0] hits;
    logic [SRC_N-1:0][21:0] dg_period;
    logic timer_start;
    logic timer_done;
    pha_cnt_t width_period;
    logic wr_opt0;
    logic wr_opt1;
    logic rd_stat;
    logic clear_req;

    // critical threshold code to percent of input limit
    function automatic logic [8:0] crit_pct(input logic [4:0] code);
        logic [8:0] pct;
        pct = CRIT_PCT_BASE + 9'(CRIT_PCT_STEP * 9'(code));
        if (code <= 5'h01) begin
            pct = CRIT_PCT_FLOOR;
        end else if (code == CRIT_CODE_450) begin
            pct = CRIT_PCT_450;
        end else if (code >= CRIT_CODE_350) begin
            pct = CRIT_PCT_350;
        end else if (code >= CRIT_CODE_300) begin
            pct = CRIT_PCT_300;
        end
        return pct;
    endfunction : crit_pct

    // critical deglitch select
    function automatic pha_cnt_t crit_deg_cyc(input logic [1:0] code);
        pha_cnt_t c;
        case (code)
            2'h0: c = pha_cnt_t'(CYC_10US);
            2'h1: c = pha_cnt_t'(P_100US);
            2'h2: c = pha_cnt_t'(P_400US);
            default: c = pha_cnt_t'(P_800US);
        endcase
        return c;
    endfunction : crit_deg_cyc

    // discharge deglitch select
    function automatic pha_cnt_t dchg_deg_cyc(input logic [1:0] code);
        pha_cnt_t c;
        case (code)
            2'h0: c = pha_cnt_t'(P_1M6);
            2'h1: c = pha_cnt_t'(P_100US);
            2'h2: c = pha_cnt_t'(P_6MS);
            default: c = pha_cnt_t'(P_12MS);
        endcase
        return c;
    endfunction : dchg_deg_cyc

    // minimum pulse width select
    function automatic pha_cnt_t width_cyc(input logic [1:0] code);
        pha_cnt_t c;
        case (code)
            2'h0: c = pha_cnt_t'(P_100US);
            2'h1: c = pha_cnt_t'(P_1MS);
            2'h2: c = pha_cnt_t'(P_10MS);
            default: c = pha_cnt_t'(P_5MS);
        endcase
        return c;
    endfunction : width_cyc

    // host access decode
    assign wr_opt0 = host_req.wr && (host_req.addr == ADDR_OPT0);
    assign wr_opt1 = host_req.wr && (host_req.addr == ADDR_OPT1);
    assign rd_stat = host_req.rd && (host_req.addr == ADDR_STAT);
    assign clear_req = wr_opt0 && !host_req.wdata[2];

    // per-source deglitch periods
    always_comb begin
        dg_period = '0;
        dg_period[SRC_COMP] = 22'(CYC_ONE);
        dg_period[SRC_CRIT] = crit_deg_cyc(s.opt0.crit_deg);
        dg_period[SRC_NOM] = s.opt0.nom_deg ? 22'(P_60MS) : 22'(P_1MS);
        dg_period[SRC_DCHG] = dchg_deg_cyc(s.opt1.dchg_deg);
        dg_period[SRC_SYSTEM_VOLTAGE_SOURCE] = 22'(CYC_20US);
        dg_period[SRC_BAT] = 22'(CYC_ONE);
        dg_period[SRC_ADP] = 22'(CYC_ONE);
    end

    // analog comparator levels filtered after synchronising
    genvar g;
    generate
        for (g = SRC_SYSTEM_VOLTAGE_SOURCE; g < SRC_N; g++) begin : g_dg
            pha_deglitch u_dg (
                .mclk(mclk),
                .rst_b(rst_b),
                .ce(ce),
                .level_in(s.sync2[g]),
                .period(dg_period[g]),
                .level_out(filt[g])
            );
        end
    endgenerate

    // presence sources fire on any change of the level
    assign filt[SRC_BAT] = s.sync2[SRC_BAT] ^ s.pres_q[1];
    assign filt[SRC_ADP] = s.sync2[SRC_ADP] ^ s.pres_q[0];
    assign events = filt;

    // profile mask, trimmed while the adapter is absent
    always_comb begin
        eff_mask = s.opt1.profile;
        if (!s.pres_q[0]) begin
            eff_mask = s.opt1.profile & KEEP_NO_ADP;
        end
    end
    assign hits = events & eff_mask;

    assign width_period = width_cyc(s.opt0.width);
    assign timer_start = (s.st == PHA_IDLE) && (|hits);

    pha_pulse_timer u_timer (
        .mclk(mclk),
        .rst_b(rst_b),
        .ce(ce),
        .start(timer_start),
        .period(width_period),
        .done(timer_done)
    );

    // next state: registers, status, alert state machine
    always_comb begin
        next_s = s;
        next_s.sync1 = sense_in;
        next_s.sync2 = s.sync1;
        next_s.pres_q = {s.sync2[SRC_BAT], s.sync2[SRC_ADP]};

        // register writes, reserved bits forced to zero
        if (wr_opt0) begin
            next_s.opt0 = pha_opt0_t'(host_req.wdata & OPT0_WMASK);
        end
        if (wr_opt1) begin
            next_s.opt1 = pha_opt1_t'(host_req.wdata & OPT1_WMASK);
        end

        // read data captured one cycle after the strobe
        if (host_req.rd) begin
            case (host_req.addr)
                ADDR_OPT0: next_s.rdata = 16'(s.opt0);
                ADDR_OPT1: next_s.rdata = 16'(s.opt1);
                ADDR_STAT: next_s.rdata = {9'h000, s.status};
                default: next_s.rdata = 16'h0000;
            endcase
        end

        // status clears on first read after release
        if (rd_stat && s.stat_armed && (s.st == PHA_IDLE)) begin
            next_s.status = 7'h00;
            next_s.stat_armed = 1'b0;
        end

        case (s.st)
            PHA_IDLE: begin
                next_s.alert_b = 1'b1;
                next_s.opt0.pulse_clear = 1'b1;
                if (|hits) begin
                    next_s.st = PHA_LOW;
                    next_s.alert_b = 1'b0;
                    next_s.status = hits;
                    next_s.stat_armed = 1'b0;
                end
            end
            PHA_LOW: begin
                next_s.alert_b = 1'b0;
                next_s.status = s.status | hits;
                if (s.opt0.ext_en) begin
                    if (clear_req && !(|hits)) begin
                        next_s.st = PHA_IDLE;
                        next_s.alert_b = 1'b1;
                        next_s.stat_armed = 1'b1;
                        next_s.opt0.pulse_clear = 1'b1;
                    end
                end else if (timer_done && !(|hits)) begin
                    next_s.st = PHA_IDLE;
                    next_s.alert_b = 1'b1;
                    next_s.stat_armed = 1'b1;
                end
            end
            default: begin
                next_s.st = PHA_IDLE;
                next_s.alert_b = 1'b1;
            end
        endcase

        // decoded thresholds toward the analog comparators
        next_s.lim.crit_pct = crit_pct(s.opt0.crit_thr);
        next_s.lim.system_voltage_source_mv = SYSTEM_VOLTAGE_SOURCE_MV_BASE + 13'(SYSTEM_VOLTAGE_SOURCE_MV_STEP * 13'(s.opt0.system_voltage_source_thr));
        next_s.lim.dchg_ma = 15'(DCHG_MA_STEP * 15'(s.opt1.dchg_thr));
    end

    // state register with reset values
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s <= '0;
            s.opt0 <= pha_opt0_t'(OPT0_RESET);
            s.opt1 <= pha_opt1_t'(OPT1_RESET);
            s.st <= PHA_IDLE;
            s.alert_b <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign processor_hot_alert_b = s.alert_b;
    assign host_rdata = s.rdata;
    assign limits = s.lim;
    assign nom_limit_pct = NOM_PCT;
endmodule : pha_alert

// [test/pha_alert_assertions.sv]
// concurrent checks on the alert block ports
`timescale 1ns/1ps
module pha_alert_assertions
    import pha_pkg::*;
#(
    parameter int P_100US = 20,
    parameter int P_1MS = 50,
    parameter int P_5MS = 70,
    parameter int P_10MS = 90
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire pha_host_req_t host_req,
    input wire logic [15:0] host_rdata,
    input wire pha_sense_t sense_in,
    input wire logic processor_hot_alert_b,
    input wire pha_limits_t limits,
    input wire logic [8:0] nom_limit_pct
);
    logic up;
    logic ext;
    logic [1:0] wid;
    logic [6:0] prof;
    logic [3:0] quiet;
    logic [21:0] low_n;
    logic wr0;
    int need;

    // minimum low time for the written width code
    always_comb begin
        case (wid)
            2'b00: need = P_100US;
            2'b01: need = P_1MS;
            2'b10: need = P_10MS;
            default: need = P_5MS;
        endcase
    end
    assign wr0 = ce && host_req.wr && host_req.addr == ADDR_OPT0;

    // shadows of written fields, quiet and low-time counters
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            up <= 1'b0;
            ext <= 1'b0;
            wid <= 2'b10;
            prof <= 7'h00;
            quiet <= 4'h0;
            low_n <= 22'h0;
        end else begin
            up <= 1'b1;
            if (wr0) begin
                ext <= host_req.wdata[5];
                wid <= host_req.wdata[4:3];
            end
            if (ce && host_req.wr && host_req.addr == ADDR_OPT1) begin
                prof <= host_req.wdata[6:0];
            end
            quiet <= (sense_in != '0) ? 4'h0 : ((quiet == 4'hF) ? quiet : quiet + 4'h1);
            low_n <= processor_hot_alert_b ? 22'h0 : low_n + 22'h1;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    // host write that ends an extended pulse with every source quiet
    sequence s_clear;
        wr0 && host_req.wdata[5] && !host_req.wdata[2] && quiet == 4'hF;
    endsequence
    sequence s_high_soon;
        ##[1:3] processor_hot_alert_b;
    endsequence

    a_idle_after_reset: assert property (!up |-> processor_hot_alert_b)
        else $error("alert low right after reset");
    a_nom_fixed: assert property (nom_limit_pct == 9'h06E)
        else $error("nominal limit not 110 percent");
    a_crit_range: assert property (up |-> limits.crit_pct >= 9'h06E && limits.crit_pct <= 9'h1C2
        && limits.crit_pct % 9'h005 == 9'h000)
        else $error("critical percent off the step grid");
    a_system_voltage_source_set: assert property (up |-> limits.system_voltage_source_mv inside {13'h1676, 13'h1770, 13'h186A, 13'h1964})
        else $error("system voltage threshold not a listed value");
    a_dchg_step: assert property (up |-> limits.dchg_ma[8:0] == 9'h000 && limits.dchg_ma <= 15'h7E00)
        else $error("discharge threshold off its step or range");
    a_stat_upper: assert property (ce && host_req.rd && host_req.addr == ADDR_STAT |=> host_rdata[15:7] == 9'h000)
        else $error("status upper bits not zero");
    a_profile_off: assert property (prof == 7'h00 && processor_hot_alert_b |=> processor_hot_alert_b)
        else $error("alert fell with empty profile");
    a_clear_ends: assert property (s_clear |-> s_high_soon)
        else $error("clear write did not release alert");
    a_min_width: assert property ($rose(processor_hot_alert_b) && !ext |-> int'(low_n) >= need)
        else $error("alert pulse shorter than width");
endmodule : pha_alert_assertions

// [test/pha_host_model.sv]
// host model: word-level register requests at falling edges
`timescale 1ns/1ps
module pha_host_model
    import pha_pkg::*;
(
    input wire logic mclk,
    input wire logic [15:0] host_rdata,
    output pha_host_req_t host_req
);
    initial host_req = '0;

    // one write; released fields show inverted values
    task automatic put(input logic [7:0] a, input logic [15:0] v);
        @(negedge mclk);
        host_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
        @(negedge mclk);
        host_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~v};
    endtask : put

    // one read; data taken one cycle after the strobe
    task automatic get(input logic [7:0] a, output logic [15:0] v);
        @(negedge mclk);
        host_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
        @(negedge mclk);
        host_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 16'hFFFF};
        v = host_rdata;
    endtask : get

    // ends an extended pulse
    task automatic clear_pulse(input logic [15:0] opt0);
        put(ADDR_OPT0, opt0 & 16'hFFFB);
    endtask : clear_pulse
endmodule : pha_host_model

// [test/test_pha_alert.sv]
// bench for the processor-hot alert block
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("Error %s expected %h seen %h", nm, exp, got); \
        end \
    end
module test_pha_alert
    import pha_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    pha_host_req_t host_req;
    logic [15:0] host_rdata;
    pha_sense_t sense_in = '0;
    logic alert_b;
    pha_limits_t limits;
    logic [8:0] nom_pct;
    logic ce = 1'b1;
    int miscompares = 0;
    int check_count = 0;
    logic [15:0] d;
    int n;

    // 50 MHz clock
    always #10 mclk = ~mclk;

    // short periods only for the timings the scenarios reach
    pha_alert #(.P_100US(20), .P_5MS(70), .P_60MS(120)) i_dut (
        .mclk(mclk), .rst_b(rst_b), .ce(ce), .host_req(host_req), .host_rdata(host_rdata),
        .sense_in(sense_in), .processor_hot_alert_b(alert_b), .limits(limits), .nom_limit_pct(nom_pct));

    pha_host_model i_host (.mclk(mclk), .host_rdata(host_rdata), .host_req(host_req));

    // waits at falling edges for an alert level, bounded
    task automatic wait_alert(input logic lvl, input int lim, output int cyc);
        cyc = 0;
        while (alert_b !== lvl && cyc < lim) begin
            @(negedge mclk);
            cyc++;
        end
    endtask : wait_alert

    // reset values, write masks, unmapped place, threshold decode
    task automatic t_regs;
        logic [4:0] codes [3] = '{5'h01, 5'h02, 5'h1B};
        logic [8:0] pct [3] = '{9'h06E, 9'h073, 9'h12C};
        i_host.get(ADDR_OPT0, d);
        `CHK("opt0 reset", 16'h4A54, d);
        i_host.get(ADDR_OPT1, d);
        `CHK("opt1 reset", 16'h8100, d);
        i_host.get(8'h3B, d);
        `CHK("unmapped read", 16'h0000, d);
        `CHK("nominal limit", 9'h06E, nom_pct);
        `CHK("crit 150", 9'h096, limits.crit_pct);
        `CHK("system_voltage_source 6000", 13'h1770, limits.system_voltage_source_mv);
        `CHK("dchg 16384", 15'h4000, limits.dchg_ma);
        i_host.put(ADDR_OPT0, 16'hFFFF);
        i_host.put(ADDR_OPT1, 16'hFFFF);
        i_host.get(ADDR_OPT0, d);
        `CHK("opt0 mask", 16'hFEFE, d);
        i_host.get(ADDR_OPT1, d);
        `CHK("opt1 mask", 16'hFF7F, d);
        `CHK("crit 450", 9'h1C2, limits.crit_pct);
        `CHK("system_voltage_source 6500", 13'h1964, limits.system_voltage_source_mv);
        `CHK("dchg max", 15'h7E00, limits.dchg_ma);
        for (int i = 0; i < 3; i++) begin
            i_host.put(ADDR_OPT0, {codes[i], 11'h254});
            i_host.get(ADDR_OPT0, d);
            `CHK("crit decode", pct[i], limits.crit_pct);
        end
        i_host.put(ADDR_OPT0, OPT0_RESET);
        i_host.put(ADDR_OPT1, OPT1_RESET);
        $display("t_regs done");
    endtask : t_regs

    // empty profile keeps the alert high with sources active
    task automatic t_off;
        @(negedge mclk);
        sense_in = 7'h7C;
        wait_alert(1'b0, 1100, n);
        `CHK("cycles before low, profile off", 1100, n);
        sense_in = '0;
        repeat (20) @(negedge mclk);
        $display("t_off done");
    endtask : t_off

    // each kept source fires alone and shows in its own status bit
    task automatic t_src;
        int src [3] = '{SRC_COMP, SRC_DCHG, SRC_SYSTEM_VOLTAGE_SOURCE};
        logic [6:0] m;
        i_host.put(ADDR_OPT0, 16'h4A44);
        for (int i = 0; i < 3; i++) begin
            m = 7'h01 << src[i];
            i_host.put(ADDR_OPT1, {9'h102, m});
            @(negedge mclk);
            sense_in = pha_sense_t'(m);
            wait_alert(1'b0, 1100, n);
            `CHK("source raises alert", 1'b0, alert_b);
            if (src[i] == SRC_SYSTEM_VOLTAGE_SOURCE) `CHK("system_voltage_source delay", 1'b1, n >= 1000 && n <= 1006);
            sense_in = '0;
            wait_alert(1'b1, 200, n);
            `CHK("pulse width", 1'b1, n >= 20 && n <= 22);
            i_host.get(ADDR_STAT, d);
            `CHK("status flag", {9'h000, m}, d);
            i_host.get(ADDR_STAT, d);
            `CHK("status cleared", 16'h0000, d);
        end
        $display("t_src done");
    endtask : t_src

    // adapter presence gates the input current sources
    task automatic t_adp;
        i_host.put(ADDR_OPT1, 16'h817F);
        @(negedge mclk);
        sense_in = 7'h30;
        wait_alert(1'b0, 200, n);
        `CHK("cycles before low, adapter absent", 200, n);
        sense_in = '0;
        i_host.put(ADDR_OPT1, 16'h8120);
        @(negedge mclk);
        sense_in = 7'h01;
        repeat (10) @(negedge mclk);
        sense_in = 7'h21;
        wait_alert(1'b0, 100, n);
        `CHK("critical with adapter", 1'b0, alert_b);
        `CHK("critical delay", 1'b1, n >= 20 && n <= 26);
        sense_in = 7'h01;
        wait_alert(1'b1, 200, n);
        i_host.get(ADDR_STAT, d);
        `CHK("critical status", 16'h0020, d);
        i_host.put(ADDR_OPT1, OPT1_RESET);
        @(negedge mclk);
        sense_in = '0;
        $display("t_adp done");
    endtask : t_adp

    // extended pulse holds until the host clears it
    task automatic t_ext;
        i_host.put(ADDR_OPT0, 16'h4A64);
        i_host.put(ADDR_OPT1, 16'h8140);
        @(negedge mclk);
        sense_in = 7'h40;
        wait_alert(1'b0, 20, n);
        @(negedge mclk);
        sense_in = '0;
        wait_alert(1'b1, 100, n);
        `CHK("extended pulse held", 100, n);
        // clear write with the clock enable low must be lost
        ce = 1'b0;
        i_host.clear_pulse(16'h4A64);
        `CHK("clear ignored, ce low", 1'b0, alert_b);
        ce = 1'b1;
        i_host.clear_pulse(16'h4A64);
        wait_alert(1'b1, 4, n);
        `CHK("pulse cleared", 1'b1, alert_b);
        i_host.get(ADDR_OPT0, d);
        `CHK("clear bit idle", 16'h4A64, d);
        i_host.put(ADDR_OPT0, OPT0_RESET);
        i_host.put(ADDR_OPT1, OPT1_RESET);
        $display("t_ext done");
    endtask : t_ext

    // battery and nominal sources with adapter in, 5 ms width, 60 ms deglitch
    task automatic t_nom;
        i_host.put(ADDR_OPT0, 16'h4A5E);
        i_host.put(ADDR_OPT1, 16'h8112);
        @(negedge mclk);
        sense_in = 7'h01;
        repeat (10) @(negedge mclk);
        sense_in = 7'h03;
        wait_alert(1'b0, 20, n);
        `CHK("battery raises alert", 1'b0, alert_b);
        wait_alert(1'b1, 200, n);
        `CHK("pulse width 5ms", 1'b1, n >= 70 && n <= 72);
        i_host.get(ADDR_STAT, d);
        `CHK("battery status", 16'h0002, d);
        sense_in = 7'h13;
        wait_alert(1'b0, 200, n);
        `CHK("nominal delay", 1'b1, n >= 120 && n <= 126);
        sense_in = 7'h03;
        wait_alert(1'b1, 200, n);
        i_host.get(ADDR_STAT, d);
        `CHK("nominal status", 16'h0010, d);
        i_host.put(ADDR_OPT1, OPT1_RESET);
        @(negedge mclk);
        sense_in = '0;
        i_host.put(ADDR_OPT0, OPT0_RESET);
        $display("t_nom done");
    endtask : t_nom

    // counts and verdict
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    // main sequence
    initial begin
        repeat (10) @(negedge mclk);
        rst_b = 1'b1;
        t_regs;
        t_off;
        t_src;
        t_adp;
        t_ext;
        t_nom;
        results;
    end

    // watchdog, well beyond the expected run
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        results;
    end
endmodule : test_pha_alert

bind pha_alert pha_alert_assertions #(.P_100US(P_100US), .P_1MS(P_1MS), .P_5MS(P_5MS), .P_10MS(P_10MS)) i_chk (
    .mclk(mclk), .rst_b(rst_b), .ce(ce), .host_req(host_req), .host_rdata(host_rdata),
    .sense_in(sense_in), .processor_hot_alert_b(processor_hot_alert_b), .limits(limits),
    .nom_limit_pct(nom_limit_pct));
